// ### rtl/mdi_cmd_done_irq.sv
`timescale 1ns/100ps

// Function
// - Slot completion sets raw bit 1-0
// - Write one clears raw bit, zero keeps
// - Masked bit equals raw and enable
// - Write one to masked clears event
// - Enable-set one enables that slot
// - Zero enable keeps masked bit low
// - Enable-set zeros leave enables unchanged
// - Enable bits map one-to-one to slots
// - Enable-clear one disables, zero ignored
// - Completion is busy bit falling edge
module mdi_cmd_done_irq #(
  parameter int NUM_SLOTS = mdi_pkg::MDI_NUM_SLOTS
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire mdi_pkg::mdi_axil_req_s i_axil,
  output mdi_pkg::mdi_axil_rsp_s o_axil,
  input wire logic [NUM_SLOTS-1:0] i_slot_busy,
  output logic [NUM_SLOTS-1:0] o_cmd_done_masked,
  output logic o_irq
);
  import mdi_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Slot bits must fit within one data word
  if (NUM_SLOTS < 1 || NUM_SLOTS > MDI_DATA_W) begin : g_bad_slots
    $error("NUM_SLOTS must lie between 1 and 32");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Bus stage registers
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [MDI_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic aw_have_q;
  logic [MDI_ADDR_W-1:0] awaddr_q;
  logic w_have_q;
  logic [MDI_DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  // Handshake and write decode strobes
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_do;
  logic wr_hit;
  logic [NUM_SLOTS-1:0] wr_bits;
  logic [NUM_SLOTS-1:0] raw_clr;
  logic [NUM_SLOTS-1:0] en_set;
  logic [NUM_SLOTS-1:0] en_clr;
  // Slot history, status and enable state
  logic [NUM_SLOTS-1:0] busy_q;
  logic [NUM_SLOTS-1:0] done_evt;
  logic [NUM_SLOTS-1:0] raw_q;
  logic [NUM_SLOTS-1:0] raw_d;
  logic [NUM_SLOTS-1:0] en_q;
  logic [NUM_SLOTS-1:0] en_d;
  logic [NUM_SLOTS-1:0] masked_q;
  logic irq_q;
  // Read word before capture
  logic [MDI_DATA_W-1:0] rd_word;
  logic rd_hit;

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  // Items move where valid meets ready
  assign aw_take = i_axil.awvalid & awready_q;
  assign w_take = i_axil.wvalid & wready_q;
  assign ar_take = i_axil.arvalid & arready_q;
  // Write runs once address and data are both held
  assign wr_do = aw_have_q & w_have_q & ~bvalid_q;

  // Write address ready, one-cycle pulse per request
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      awready_q <= 1'b0;
    end else begin
      awready_q <= i_axil.awvalid & ~awready_q & ~aw_have_q & ~bvalid_q;
    end
  end

  // Write data ready, one-cycle pulse per request
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wready_q <= 1'b0;
    end else begin
      wready_q <= i_axil.wvalid & ~wready_q & ~w_have_q & ~bvalid_q;
    end
  end

  // Address holding stage
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      awaddr_q <= i_axil.awaddr;
    end else if (wr_do) begin
      aw_have_q <= 1'b0;
    end
  end

  // Data holding stage
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      wdata_q <= i_axil.wdata;
      wstrb_q <= i_axil.wstrb;
    end else if (wr_do) begin
      w_have_q <= 1'b0;
    end
  end

  // Write response, held until bready
  // No new write is accepted while this stands
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bvalid_q <= 1'b0;
      bresp_q <= MDI_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? MDI_RESP_OKAY : MDI_RESP_SLVERR;
    end else if (bvalid_q && i_axil.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read address ready, one-cycle pulse per request
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      arready_q <= 1'b0;
    end else begin
      arready_q <= i_axil.arvalid & ~arready_q & ~rvalid_q;
    end
  end

  // Read data, captured at address hand-off, held until rready
  // Address decode is sampled on the hand-off edge
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= MDI_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? MDI_RESP_OKAY : MDI_RESP_SLVERR;
    end else if (rvalid_q && i_axil.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Slot bits sit in byte lane 0 only
  always_comb begin
    wr_bits = wstrb_q[0] ? wdata_q[MDI_SLOT_LSB +: NUM_SLOTS] : '0;
    raw_clr = '0;
    en_set = '0;
    en_clr = '0;
    wr_hit = 1'b1;
    case (awaddr_q)
      MDI_OFS_RAW: begin
        raw_clr = wr_bits;
      end
      MDI_OFS_MASKED: begin
        raw_clr = wr_bits;
      end
      MDI_OFS_EN_SET: begin
        en_set = wr_bits;
      end
      MDI_OFS_EN_CLR: begin
        en_clr = wr_bits;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
    // Nothing lands outside the write edge
    if (!wr_do) begin
      raw_clr = '0;
      en_set = '0;
      en_clr = '0;
    end
  end

  // ----------------------------------------------------------------
  // Completion events
  // ----------------------------------------------------------------
  // Busy level of each slot, previous cycle
  // Cleared history: a slot busy across reset still reports
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      busy_q <= '0;
    end else begin
      busy_q <= i_slot_busy;
    end
  end

  // Busy falling edge marks a finished command
  assign done_evt = busy_q & ~i_slot_busy;

  // ----------------------------------------------------------------
  // Status and enable state
  // ----------------------------------------------------------------
  // Per-slot next values, same bit order everywhere
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    always_comb begin
      raw_d[s] = (raw_q[s] & ~raw_clr[s]) | done_evt[s];
      en_d[s] = (en_q[s] & ~en_clr[s]) | en_set[s];
    end
  end

  // Sticky raw completion bits
  // Event wins over a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      raw_q <= MDI_RST_RAW[NUM_SLOTS-1:0];
    end else begin
      raw_q <= raw_d;
    end
  end

  // Enable mask
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      en_q <= MDI_RST_EN[NUM_SLOTS-1:0];
    end else begin
      en_q <= en_d;
    end
  end

  // Masked bits and interrupt line
  // Built from next values so pins track the registers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      masked_q <= '0;
      irq_q <= 1'b0;
    end else begin
      masked_q <= raw_d & en_d;
      irq_q <= |(raw_d & en_d);
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Unused upper bits stay zero
  // Misaligned or unknown addresses answer with an error
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (i_axil.araddr)
      MDI_OFS_RAW: begin
        rd_word[MDI_SLOT_LSB +: NUM_SLOTS] = raw_q;
      end
      MDI_OFS_MASKED: begin
        rd_word[MDI_SLOT_LSB +: NUM_SLOTS] = raw_q & en_q;
      end
      MDI_OFS_EN_SET, MDI_OFS_EN_CLR: begin
        rd_word[MDI_SLOT_LSB +: NUM_SLOTS] = en_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes straight from a flip-flop
  assign o_axil.awready = awready_q;
  assign o_axil.wready = wready_q;
  assign o_axil.bvalid = bvalid_q;
  assign o_axil.bresp = bresp_q;
  assign o_axil.arready = arready_q;
  assign o_axil.rvalid = rvalid_q;
  assign o_axil.rdata = rdata_q;
  assign o_axil.rresp = rresp_q;
  assign o_cmd_done_masked = masked_q;
  assign o_irq = irq_q;

endmodule // mdi_cmd_done_irq

// ### rtl/mdi_pkg.sv
package mdi_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the AXI4-Lite port
  // ----------------------------------------------------------------
  localparam logic [31:0] MDI_OFS_RAW = 32'h0000_0000;
  localparam logic [31:0] MDI_OFS_MASKED = 32'h0000_0004;
  localparam logic [31:0] MDI_OFS_EN_SET = 32'h0000_0008;
  localparam logic [31:0] MDI_OFS_EN_CLR = 32'h0000_000C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MDI_SLOT_LSB = 0;
  localparam int MDI_NUM_SLOTS = 2;
  localparam int MDI_DATA_W = 32;
  localparam int MDI_ADDR_W = 32;
  localparam logic [31:0] MDI_RST_RAW = 32'h0000_0000;
  localparam logic [31:0] MDI_RST_EN = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus answer codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MDI_RESP_OKAY = 2'h0;
  localparam logic [1:0] MDI_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // AXI4-Lite carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [MDI_ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [MDI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [MDI_ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } mdi_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [MDI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } mdi_axil_rsp_s;

endpackage

// ### testbench/mdi_cmd_done_irq_props.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker for the completion interrupt block
// ----------------------------------------------------------------
module mdi_cmd_done_irq_props
  import mdi_pkg::*;
#(
  parameter int NUM_SLOTS = 2
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire mdi_pkg::mdi_axil_req_s i_axil,
  input wire mdi_pkg::mdi_axil_rsp_s o_axil,
  input wire logic [NUM_SLOTS-1:0] i_slot_busy,
  input wire logic [NUM_SLOTS-1:0] o_cmd_done_masked,
  input wire logic o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // Interrupt line and masked bits
  a_irq_any: assert property (
    o_irq == |o_cmd_done_masked) else $error("irq differs from masked");
  a_masked_rise: assert property (
    !$rose(o_axil.bvalid) |-> (o_cmd_done_masked & ~$past(o_cmd_done_masked)
    & ~($past(i_slot_busy, 2) & ~$past(i_slot_busy))) == '0)
    else $error("masked bit rose without cause");
  a_masked_fall: assert property (
    ($past(o_cmd_done_masked) & ~o_cmd_done_masked) != '0
    |-> $rose(o_axil.bvalid)) else $error("masked bit fell without write");
  // Bus handshakes
  a_aw_pulse: assert property (
    o_axil.awready |=> !o_axil.awready) else $error("awready too long");
  a_b_hold: assert property (o_axil.bvalid && !i_axil.bready
    |=> o_axil.bvalid && $stable(o_axil.bresp)) else $error("b dropped");
  a_r_hold: assert property (o_axil.rvalid && !i_axil.rready
    |=> o_axil.rvalid && $stable(o_axil.rdata)) else $error("r dropped");
  a_rsvd_zero: assert property (
    o_axil.rvalid |-> o_axil.rdata[31:2] == 30'h0) else $error("rsvd set");
  a_b_time: assert property (o_axil.awready && i_axil.awvalid
    && o_axil.wready && i_axil.wvalid |-> ##[1:2] o_axil.bvalid)
    else $error("write answer late");
  a_r_time: assert property (o_axil.arready && i_axil.arvalid
    |=> o_axil.rvalid) else $error("read answer late");
endmodule // mdi_cmd_done_irq_props

bind mdi_cmd_done_irq mdi_cmd_done_irq_props #(.NUM_SLOTS(NUM_SLOTS))
  mdi_cmd_done_irq_props_i (.i_core_clk, .i_srst, .i_axil, .o_axil,
  .i_slot_busy, .o_cmd_done_masked, .o_irq);

// ### testbench/test_mdio_cmd_done_irq.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module test_mdio_cmd_done_irq;
  import mdi_pkg::*;
  typedef struct {
    logic [1:0] op;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic q;
  } mdi_row_s;
  logic clk = 0;
  logic srst = 1;
  logic [1:0] busy = 0;
  mdi_axil_req_s req = '0;
  mdi_axil_rsp_s rsp;
  logic [1:0] irqm;
  logic irq;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [3:0] strb = 4'hF;
  int err_total = 0;
  int samples_checked = 0;
  mdi_row_s rows[23];

  // Clock, 5 ns period
  always #2.5 clk = ~clk;

  mdi_cmd_done_irq #(.NUM_SLOTS(2)) mdi_cmd_done_irq_i (.i_core_clk(clk),
    .i_srst(srst), .i_axil(req), .o_axil(rsp), .i_slot_busy(busy),
    .o_cmd_done_masked(irqm), .o_irq(irq));

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", s, e, g);
      err_total++;
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 50) begin
      chk("timeout", 0, 1);
      end_sim();
    end
  endtask

  // Write word; drop busy bits on the handshake edge
  task automatic wr(input logic [31:0] a, d, input logic [1:0] drop);
    int n;
    logic aw_p;
    logic w_p;
    @(posedge clk);
    aw_p = 1'b1;
    w_p = 1'b1;
    req.awvalid <= 1;
    req.awaddr <= a;
    req.wvalid <= 1;
    req.wdata <= d;
    req.wstrb <= strb;
    req.bready <= 1;
    for (n = 0; n < 50 && (aw_p || w_p); n++) begin
      @(posedge clk);
      if (aw_p && rsp.awready) begin
        req.awvalid <= 0;
        aw_p = 1'b0;
      end
      if (w_p && rsp.wready) begin
        req.wvalid <= 0;
        w_p = 1'b0;
      end
    end
    tmo(n);
    busy <= busy & ~drop;
    for (n = 0; n < 50 && !rsp.bvalid; n++) @(posedge clk);
    tmo(n);
    rr = rsp.bresp;
    req.bready <= 0;
  endtask

  task automatic rd(input logic [31:0] a);
    int n;
    logic ar_p;
    @(posedge clk);
    ar_p = 1'b1;
    req.arvalid <= 1;
    req.araddr <= a;
    req.rready <= 1;
    for (n = 0; n < 50 && ar_p; n++) begin
      @(posedge clk);
      if (rsp.arready) begin
        req.arvalid <= 0;
        ar_p = 1'b0;
      end
    end
    tmo(n);
    for (n = 0; n < 50 && !rsp.rvalid; n++) @(posedge clk);
    tmo(n);
    rv = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 0;
  endtask

  // Completion event: busy high one cycle then falling
  task automatic ev(input logic [1:0] m);
    @(posedge clk) busy <= m;
    @(posedge clk) busy <= 0;
    repeat (3) @(posedge clk);
  endtask

  // Main sequence: op 0 write, 1 read, 2 event
  initial begin
    rows = '{'{2, 0, 3, 0, 0}, '{1, 0, 0, 3, 0}, '{1, 4, 0, 0, 0},
      '{0, 8, 1, 0, 1}, '{1, 8, 0, 1, 1}, '{1, 4, 0, 1, 1}, '{0, 8, 0, 0, 1},
      '{1, 12, 0, 1, 1}, '{0, 8, 2, 0, 1}, '{1, 4, 0, 3, 1},
      '{0, 12, 1, 0, 1}, '{1, 8, 0, 2, 1}, '{0, 12, 0, 0, 1},
      '{1, 4, 0, 2, 1}, '{0, 0, 1, 0, 1}, '{1, 0, 0, 2, 1}, '{0, 0, 0, 0, 1},
      '{0, 4, 2, 0, 0}, '{1, 0, 0, 0, 0}, '{2, 0, 1, 0, 0}, '{1, 0, 0, 1, 0},
      '{0, 8, 1, 0, 1}, '{0, 4, 1, 0, 0}};
    repeat (8) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    foreach (rows[i]) begin
      case (rows[i].op)
        0: wr(rows[i].a, rows[i].d, 2'h0);
        1: rd(rows[i].a);
        default: ev(rows[i].d[1:0]);
      endcase
      if (rows[i].op == 1) chk("rdata", rows[i].x, rv);
      if (rows[i].op == 1 && rows[i].a == MDI_OFS_MASKED) begin
        chk("masked pin", rows[i].x, {30'h0, irqm});
      end
      if (rows[i].op != 2) chk("resp", {30'h0, MDI_RESP_OKAY}, {30'h0, rr});
      chk("irq", {31'h0, rows[i].q}, {31'h0, irq});
    end
    // Event on the same edge as its clear write
    ev(2'h1);
    @(posedge clk) busy <= 2'h1;
    wr(MDI_OFS_RAW, 32'h1, 2'h1);
    rd(MDI_OFS_RAW);
    chk("raw kept", 32'h1, rv);
    // Unmapped address
    wr(32'h10, 32'h3, 2'h0);
    chk("bresp", {30'h0, MDI_RESP_SLVERR}, {30'h0, rr});
    rd(32'h10);
    chk("rresp", {30'h0, MDI_RESP_SLVERR}, {30'h0, rr});
    chk("unmapped", 32'h0, rv);
    // Lane 0 strobe off: the write is ignored
    strb = 4'hE;
    wr(MDI_OFS_EN_CLR, 32'h3, 2'h0);
    strb = 4'hF;
    chk("strobe resp", {30'h0, MDI_RESP_OKAY}, {30'h0, rr});
    rd(MDI_OFS_EN_SET);
    chk("strobe", 32'h3, rv);
    // Second reset clears every register
    @(posedge clk) srst <= 1;
    repeat (8) @(posedge clk);
    srst <= 0;
    for (int a = 0; a < 16; a += 4) begin
      rd(a);
      chk("reset", (a < 8) ? MDI_RST_RAW : MDI_RST_EN, rv);
    end
    chk("irq reset", 32'h0, {31'h0, irq});
    chk("masked reset", 32'h0, {30'h0, irqm});
    end_sim();
  end
endmodule // test_mdio_cmd_done_irq
